// ### verilog/cwd_defs.svh
// Purpose: constants of the option word decoder
// Assumes: 16-bit option words, APB byte addresses from 14-bit word index
// Notes: index times four gives the byte address
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH

`define CWD_WORD_W 16
`define CWD_IDX_W 14
`define CWD_WORD1_INDEX 14'h2007
`define CWD_WORD2_INDEX 14'h2008
`define CWD_CFG_LO_INDEX 14'h2000
`define CWD_CFG_HI_INDEX 14'h3fff
`define CWD_STATUS_INDEX 14'h0000
`define CWD_ERASED 16'hffff
`define CWD_UNIMPL_MASK 16'hc000
`define CWD_DEBUG_BIT 13
`define CWD_LVP_BIT 12
`define CWD_FCM_BIT 11
`define CWD_SWITCH_BIT 10
`define CWD_BOR_HI_BIT 9
`define CWD_BOR_LO_BIT 8
`define CWD_DPROT_BIT 7
`define CWD_PPROT_BIT 6
`define CWD_ST_LOADED_BIT 0
`define CWD_ST_PROG_BIT 1

`endif

// ### verilog/cwd_pkg.sv
// Purpose: types of the option word decoder
// Assumes: nothing beyond the defs header
// Notes: enum order follows the two-bit brown-out encoding
`default_nettype none
package cwd_pkg;
    typedef logic [15:0] cwd_word_t;
    typedef enum logic [1:0] {BOR_OFF, BOR_SOFT, BOR_RUN_ONLY, BOR_ALWAYS} cwd_bor_e;
    typedef enum logic [1:0] {LD_FETCH, LD_CAPTURE, LD_HOLD} cwd_load_e;
    typedef enum logic [1:0] {AP_IDLE, AP_READ, AP_RESP, AP_DONE} cwd_apb_e;
endpackage : cwd_pkg
`default_nettype wire

// ### verilog/cwd_word_store.sv
// Purpose: two non-volatile option words with registered read
// Assumes: powerOnResetn models the erased state of a blank part
// Notes: resetn does not touch the stored words
`include "cwd_defs.svh"
`default_nettype none
module cwd_word_store (
    input wire logic sys_clk,
    input wire logic powerOnResetn,
    input wire logic clkEn,
    input wire logic rdSel,
    input wire logic wrEn,
    input wire logic wrSel,
    input wire cwd_pkg::cwd_word_t wrData,
    output var cwd_pkg::cwd_word_t rdData
);
    import cwd_pkg::*;

    cwd_word_t words [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gWord
            always_ff @(posedge sys_clk or negedge powerOnResetn)
            begin
                if (!powerOnResetn)
                    words[g] <= `CWD_ERASED;
                else if (clkEn && wrEn && (wrSel == 1'(g)))
                    words[g] <= wrData;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge powerOnResetn)
    begin
        if (!powerOnResetn)
            rdData <= `CWD_ERASED;
        else if (clkEn)
            rdData <= words[rdSel];
    end
endmodule : cwd_word_store
`default_nettype wire

// ### verilog/cwd_option_decode.sv
// Purpose: option word one and two store access and option decode
// Assumes: APB master, sys_clk 20 MHz, synchronous pin inputs
// Notes: options latch once after each reset release
//
// Chosen here: the APB interface to the registers.
`include "cwd_defs.svh"
`default_nettype none
module cwd_option_decode (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic powerOnResetn,
    input wire logic clkEn,
    input wire logic progModeEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic optionsValid,
    output logic debuggerEn,
    output logic progPinsGpio,
    output logic lowvoltProgrammingEn,
    output logic lowvoltEntryPinIo,
    output logic failsafeMonitorEn,
    output logic clockSwitchoverEn,
    output var cwd_pkg::cwd_bor_e brownoutPolicy,
    output logic brownoutRunEn,
    output logic brownoutSleepEn,
    output logic softBrownoutCtl,
    output logic dataMemProtectN,
    output logic programMemProtectN
);
    import cwd_pkg::*;

    function automatic logic cwdInCfg(input logic [13:0] idx);
        return (idx >= `CWD_CFG_LO_INDEX) && (idx <= `CWD_CFG_HI_INDEX);
    endfunction : cwdInCfg

    cwd_load_e ldState_q;
    cwd_apb_e apState_q;
    logic [13:0] reqIdx_q;
    logic reqAlign_q;
    logic reqWrite_q;
    logic reqProg_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [31:0] respData;
    logic respErr;
    logic setupTake;
    logic doneTake;
    logic reqCfg;
    logic reqWord1;
    logic reqWord2;
    logic memRdSel;
    logic memWrEn;
    cwd_word_t memRd;
    logic optionsValid_q;
    logic debuggerEn_q;
    logic progPinsGpio_q;
    logic lowvoltProgrammingEn_q;
    logic lowvoltEntryPinIo_q;
    logic failsafeMonitorEn_q;
    logic clockSwitchoverEn_q;
    cwd_bor_e brownoutPolicy_q;
    cwd_bor_e borField;
    logic brownoutRunEn_q;
    logic brownoutSleepEn_q;
    logic softBrownoutCtl_q;
    logic dataMemProtectN_q;
    logic programMemProtectN_q;

    assign reqCfg = cwdInCfg(reqIdx_q);
    assign reqWord1 = (reqIdx_q == `CWD_WORD1_INDEX);
    assign reqWord2 = (reqIdx_q == `CWD_WORD2_INDEX);
    assign setupTake = clkEn && (apState_q == AP_IDLE) && psel && (ldState_q == LD_HOLD);
    assign doneTake = clkEn && (apState_q == AP_DONE) && psel && penable && pready_q;
    assign memRdSel = (ldState_q == LD_HOLD) && reqWord2;
    assign borField = cwd_bor_e'(memRd[`CWD_BOR_HI_BIT:`CWD_BOR_LO_BIT]);

    assign memWrEn = doneTake && reqWrite_q && !pslverr_q && (reqWord1 || reqWord2);

    cwd_word_store uStore (
        .sys_clk(sys_clk),
        .powerOnResetn(powerOnResetn),
        .clkEn(clkEn),
        .rdSel(memRdSel),
        .wrEn(memWrEn),
        .wrSel(reqWord2),
        .wrData(pwdata[15:0]),
        .rdData(memRd)
    );

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            ldState_q <= LD_FETCH;
        else if (clkEn)
        begin
            case (ldState_q)
                LD_FETCH: ldState_q <= LD_CAPTURE;
                LD_CAPTURE: ldState_q <= LD_HOLD;
                LD_HOLD: ldState_q <= LD_HOLD;
                default: ldState_q <= LD_FETCH;
            endcase
        end
    end

    // request capture at setup
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reqIdx_q <= `CWD_STATUS_INDEX;
            reqAlign_q <= 1'b1;
            reqWrite_q <= 1'b0;
            reqProg_q <= 1'b0;
        end
        else if (setupTake)
        begin
            reqIdx_q <= paddr[15:2];
            reqAlign_q <= (paddr[1:0] == 2'h0);
            reqWrite_q <= pwrite;
            reqProg_q <= progModeEn;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            apState_q <= AP_IDLE;
        else if (clkEn)
        begin
            case (apState_q)
                AP_IDLE: if (setupTake) apState_q <= AP_READ;
                AP_READ: apState_q <= AP_RESP;
                AP_RESP: apState_q <= AP_DONE;
                AP_DONE: if (doneTake) apState_q <= AP_IDLE;
                default: apState_q <= AP_IDLE;
            endcase
        end
    end

    always_comb
    begin
        respData = 32'h0;
        respErr = 1'b0;
        if (!reqAlign_q)
            respErr = 1'b1;
        else if (reqIdx_q == `CWD_STATUS_INDEX)
        begin
            respData[`CWD_ST_LOADED_BIT] = optionsValid_q;
            respData[`CWD_ST_PROG_BIT] = progModeEn;
        end
        else if (reqCfg && reqProg_q)
        begin
            if (reqWord1)
                respData[15:0] = memRd | `CWD_UNIMPL_MASK;
            else if (reqWord2)
                respData[15:0] = memRd;
            else
                respData[15:0] = `CWD_ERASED;
        end
        else
            respErr = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (apState_q == AP_RESP)
            begin
                pready_q <= 1'b1;
                prdata_q <= reqWrite_q ? 32'h0 : respData;
                pslverr_q <= respErr;
            end
            else if (doneTake)
            begin
                pready_q <= 1'b0;
                prdata_q <= 32'h0;
                pslverr_q <= 1'b0;
            end
        end
    end

    // option latches, erased defaults in reset
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            optionsValid_q <= 1'b0;
            debuggerEn_q <= 1'b0;
            progPinsGpio_q <= 1'b1;
            lowvoltProgrammingEn_q <= 1'b1;
            lowvoltEntryPinIo_q <= 1'b0;
            failsafeMonitorEn_q <= 1'b1;
            clockSwitchoverEn_q <= 1'b1;
            brownoutPolicy_q <= BOR_ALWAYS;
            brownoutRunEn_q <= 1'b1;
            brownoutSleepEn_q <= 1'b1;
            softBrownoutCtl_q <= 1'b0;
            dataMemProtectN_q <= 1'b1;
            programMemProtectN_q <= 1'b1;
        end
        else if (clkEn && (ldState_q == LD_CAPTURE))
        begin
            optionsValid_q <= 1'b1;
            debuggerEn_q <= !memRd[`CWD_DEBUG_BIT];
            progPinsGpio_q <= memRd[`CWD_DEBUG_BIT];
            lowvoltProgrammingEn_q <= memRd[`CWD_LVP_BIT];
            lowvoltEntryPinIo_q <= !memRd[`CWD_LVP_BIT];
            failsafeMonitorEn_q <= memRd[`CWD_FCM_BIT];
            clockSwitchoverEn_q <= memRd[`CWD_SWITCH_BIT];
            brownoutPolicy_q <= borField;
            brownoutRunEn_q <= (borField == BOR_ALWAYS) || (borField == BOR_RUN_ONLY);
            brownoutSleepEn_q <= (borField == BOR_ALWAYS);
            softBrownoutCtl_q <= (borField == BOR_SOFT);
            dataMemProtectN_q <= memRd[`CWD_DPROT_BIT];
            programMemProtectN_q <= memRd[`CWD_PPROT_BIT];
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign optionsValid = optionsValid_q;
    assign debuggerEn = debuggerEn_q;
    assign progPinsGpio = progPinsGpio_q;
    assign lowvoltProgrammingEn = lowvoltProgrammingEn_q;
    assign lowvoltEntryPinIo = lowvoltEntryPinIo_q;
    assign failsafeMonitorEn = failsafeMonitorEn_q;
    assign clockSwitchoverEn = clockSwitchoverEn_q;
    assign brownoutPolicy = brownoutPolicy_q;
    assign brownoutRunEn = brownoutRunEn_q;
    assign brownoutSleepEn = brownoutSleepEn_q;
    assign softBrownoutCtl = softBrownoutCtl_q;
    assign dataMemProtectN = dataMemProtectN_q;
    assign programMemProtectN = programMemProtectN_q;

    default clocking cbMain @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_answer_latency: assert property (
        setupTake ##1 clkEn [*2] |=> pready_q)
        else $error("answer not two wait states after setup");

    a_cfg_locked: assert property (
        pready_q && cwdInCfg(reqIdx_q) && reqAlign_q && !reqProg_q
        |-> pslverr_q && (prdata_q == 32'h0))
        else $error("configuration space reached outside programming mode");

    // aligned word-one read returns the unimplemented bits 15:14 as one
    a_unimpl_ones: assert property (
        pready_q && reqWord1 && reqAlign_q && reqProg_q && !reqWrite_q
        |-> prdata_q[15:14] == 2'h3)
        else $error("unimplemented bits not read as one");

    a_erased_fill: assert property (
        pready_q && reqCfg && reqProg_q && reqAlign_q && !reqWord1 && !reqWord2 && !reqWrite_q
        |-> prdata_q == 32'h0000ffff)
        else $error("unused configuration location not erased");

    a_word_write: assert property (
        memWrEn |-> (reqIdx_q == 14'h2007 || reqIdx_q == 14'h2008) && reqProg_q)
        else $error("store written at a wrong location");

    a_debug_pins: assert property (
        ldState_q == LD_CAPTURE && clkEn
        |=> debuggerEn_q == !$past(memRd[13]) && progPinsGpio_q != debuggerEn_q)
        else $error("debugger pin ownership wrong");

    a_lowvolt_pin: assert property (
        ldState_q == LD_CAPTURE && clkEn
        |=> lowvoltProgrammingEn_q == $past(memRd[12])
        && lowvoltEntryPinIo_q == !lowvoltProgrammingEn_q)
        else $error("low-voltage pin function wrong");

    a_clock_opts: assert property (
        ldState_q == LD_CAPTURE && clkEn
        |=> failsafeMonitorEn_q == $past(memRd[11])
        && clockSwitchoverEn_q == $past(memRd[10]))
        else $error("clock option decode wrong");

    a_brownout_decode: assert property (
        optionsValid_q
        |-> brownoutSleepEn_q == (brownoutPolicy_q == BOR_ALWAYS)
        && softBrownoutCtl_q == (brownoutPolicy_q == BOR_SOFT)
        && brownoutRunEn_q == brownoutPolicy_q[1])
        else $error("brown-out policy decode wrong");

    a_protect_bits: assert property (
        ldState_q == LD_CAPTURE && clkEn
        |=> dataMemProtectN_q == $past(memRd[7])
        && programMemProtectN_q == $past(memRd[6]))
        else $error("protection decode wrong");

    a_options_static: assert property (
        optionsValid_q
        |=> optionsValid_q && $stable(brownoutPolicy_q) && $stable(debuggerEn_q)
        && $stable(dataMemProtectN_q) && $stable(programMemProtectN_q))
        else $error("options changed before the next reset");

endmodule : cwd_option_decode
`default_nettype wire

// ### verilog/cwd_option_decode_unused_guard.sv
// Purpose: none
// Assumes: none
// Notes: none

// ### tb/cwd_programmer.sv
// Purpose: programmer model driving the option word bus
// Assumes: one transfer at a time, started by a one-cycle start pulse
// Notes: released address and data lines show the inverse of the last value
`default_nettype none
module cwd_programmer (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic reqWrite,
    input wire logic [15:0] reqAddr,
    input wire logic [31:0] reqData,
    input wire logic modeReq,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic progModeEn,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [15:0] paddr,
    output logic [31:0] pwdata,
    output logic done,
    output logic [31:0] rdData,
    output logic err
);
    timeunit 1ns;
    timeprecision 1ps;
    assign progModeEn = modeReq;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 16'h0000;
            pwdata <= 32'h00000000;
            done <= 1'b0;
            rdData <= 32'h00000000;
            err <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (psel && penable && pready)
            begin
                rdData <= prdata;
                err <= pslverr;
                done <= 1'b1;
                psel <= 1'b0;
                penable <= 1'b0;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end
            else if (psel)
                penable <= 1'b1;
            else if (start)
            begin
                psel <= 1'b1;
                pwrite <= reqWrite;
                paddr <= reqAddr;
                pwdata <= reqData;
            end
        end
    end
endmodule : cwd_programmer
`default_nettype wire

// ### tb/cwd_option_decode_tb.sv
// Purpose: self-checking bench of the option word decoder
// Assumes: programmer model in front of the bus, clkEn mostly high
// Notes: expectations derive from the bit meanings, not the design
`include "cwd_defs.svh"
`default_nettype none
module cwd_option_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] W1 = {`CWD_WORD1_INDEX, 2'b00};
    localparam logic [15:0] W2 = {`CWD_WORD2_INDEX, 2'b00};
    typedef struct {logic [15:0] word; logic [31:0] rdExp;} cwd_row_s;
    cwd_row_s rows [4] = '{'{16'h0000, 32'h0000c000}, '{16'h3fff, 32'h0000ffff},
        '{16'h2940, 32'h0000e940}, '{16'h1680, 32'h0000d680}};
    logic sys_clk = 0, resetn = 0, powerOnResetn = 0, clkEn = 1, modeReq = 0;
    logic start = 0, reqWrite = 0, progModeEn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] reqAddr = 16'h0000, paddr;
    logic [31:0] reqData = 0, pwdata, prdata, rdData, rd, lastRd;
    logic done, err, er, optionsValid, debuggerEn, progPinsGpio, lowvoltProgrammingEn;
    logic lowvoltEntryPinIo, failsafeMonitorEn, clockSwitchoverEn, brownoutRunEn;
    logic brownoutSleepEn, softBrownoutCtl, dataMemProtectN, programMemProtectN;
    cwd_pkg::cwd_bor_e brownoutPolicy;
    logic [12:0] optSeen;
    int errors = 0, num_checks = 0, cycles = 0;
    assign optSeen = {debuggerEn, progPinsGpio, lowvoltProgrammingEn, lowvoltEntryPinIo,
        failsafeMonitorEn, clockSwitchoverEn, brownoutPolicy, brownoutRunEn,
        brownoutSleepEn, softBrownoutCtl, dataMemProtectN, programMemProtectN};
    always #25 sys_clk = ~sys_clk;
    cwd_programmer i_prog (.sys_clk(sys_clk), .resetn(resetn), .start(start),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .modeReq(modeReq),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .progModeEn(progModeEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .done(done), .rdData(rdData), .err(err));
    cwd_option_decode i_dut (.sys_clk(sys_clk), .resetn(resetn),
        .powerOnResetn(powerOnResetn), .clkEn(clkEn), .progModeEn(progModeEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .optionsValid(optionsValid),
        .debuggerEn(debuggerEn), .progPinsGpio(progPinsGpio),
        .lowvoltProgrammingEn(lowvoltProgrammingEn), .lowvoltEntryPinIo(lowvoltEntryPinIo),
        .failsafeMonitorEn(failsafeMonitorEn), .clockSwitchoverEn(clockSwitchoverEn),
        .brownoutPolicy(brownoutPolicy), .brownoutRunEn(brownoutRunEn),
        .brownoutSleepEn(brownoutSleepEn), .softBrownoutCtl(softBrownoutCtl),
        .dataMemProtectN(dataMemProtectN), .programMemProtectN(programMemProtectN));
    function automatic logic [12:0] expOpt(input logic [15:0] w);
        return {~w[13], w[13], w[12], ~w[12], w[11], w[10], w[9:8], w[9],
            w[9:8] == 2'b11, w[9:8] == 2'b01, w[7], w[6]};
    endfunction : expOpt
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        start <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqData <= d;
        @(posedge sys_clk);
        start <= 1'b0;
        while (done !== 1'b1 && n < 60)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 60)
            errors++;
        rd = rdData;
        er = err;
    endtask : apb
    task automatic doReset(input logic [15:0] w);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check(optSeen, expOpt(16'hffff));
        check(optionsValid, 0);
        resetn <= 1'b1;
        powerOnResetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(optionsValid, 0);
        @(posedge sys_clk);
        check(optionsValid, 1);
        check(optSeen, expOpt(w));
    endtask : doReset
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            finish_test();
        end
    end
    initial
    begin
        doReset(16'hffff);
        modeReq <= 1'b1;
        apb(0, W1, 0);
        check(rd, 32'h0000ffff);
        // table of option words, all four brown-out codes
        foreach (rows[i])
        begin
            apb(1, W1, {16'hffff, rows[i].word});
            check(er, 0);
            apb(0, W1, 0);
            check(rd, rows[i].rdExp);
            doReset(rows[i].word);
            apb(1, W1, {16'h0000, ~rows[i].word});
            repeat (5) @(posedge sys_clk);
            check(optSeen, expOpt(rows[i].word));
            lastRd = {16'h0000, ~rows[i].word | 16'hc000};
        end
        apb(1, W2, 32'h00001234);
        apb(0, W2, 0);
        check(rd, 32'h00001234);
        apb(0, W1, 0);
        check(rd, lastRd);
        apb(0, 16'h8000, 0);
        check(er, 0);
        check(rd, 32'h0000ffff);
        apb(0, 16'h0000, 0);
        check(rd, 32'h00000003);
        // configuration space refused outside programming mode
        modeReq <= 1'b0;
        apb(0, W1, 0);
        check(er, 1);
        check(rd, 32'h0);
        apb(1, W1, 32'h00000000);
        check(er, 1);
        apb(0, 16'h0000, 0);
        check(rd, 32'h00000001);
        modeReq <= 1'b1;
        apb(0, W1, 0);
        check(rd, lastRd);
        apb(0, 16'h801e, 0);
        check(er, 1);
        apb(0, 16'h4000, 0);
        check(er, 1);
        fork
            apb(0, W2, 0);
            begin
                repeat (3) @(posedge sys_clk);
                clkEn <= 1'b0;
                repeat (3) @(posedge sys_clk);
                clkEn <= 1'b1;
            end
        join
        check(er, 0);
        check(rd, 32'h00001234);
        finish_test();
    end
endmodule : cwd_option_decode_tb
`default_nettype wire
